// file: rtl/pwm_seq_defines.vh
// Register offsets, field positions, load mode codes and reset values of the sequence decoder.
`ifndef PWM_SEQ_DEFINES_VH
`define PWM_SEQ_DEFINES_VH
`define REG_TASK_STOP 12'h004
`define REG_TASK_BEGIN0 12'h008
`define REG_TASK_BEGIN1 12'h00c
`define REG_TASK_ADVANCE 12'h010
`define REG_EVT_HALTED 12'h104
`define REG_EVT_BEGUN0 12'h108
`define REG_EVT_BEGUN1 12'h10c
`define REG_EVT_FINISHED0 12'h110
`define REG_EVT_FINISHED1 12'h114
`define REG_EVT_PERIOD 12'h118
`define REG_EVT_REPEATS 12'h11c
`define REG_ENABLE 12'h500
`define REG_COUNT_DIR 12'h504
`define REG_PERIOD_TOP 12'h508
`define REG_CLK_DIV 12'h50c
`define REG_DECODER 12'h510
`define REG_REPEAT 12'h514
`define REG_SEQ0_BASE 12'h520
`define REG_SEQ1_BASE 12'h540
`define SEQ_PTR_OFS 12'h000
`define SEQ_LEN_OFS 12'h004
`define SEQ_EXTRA_OFS 12'h008
`define SEQ_DELAY_OFS 12'h00c
`define REG_STATUS 12'h600
`define LOAD_COMMON 2'h0
`define LOAD_GROUPED 2'h1
`define LOAD_INDIVIDUAL 2'h2
`define LOAD_WAVE 2'h3
`define DEC_LOAD_LSB 0
`define DEC_MODE_BIT 8
`define POL_BIT 15
`define TOP_RESET 15'h3fff
`endif

// file: rtl/pwm_wave_counter.v
// Wave counter: 15-bit up or up-and-down counter with four compare channels.
`timescale 1ns/1ps
module pwm_wave_counter #(
  parameter W = 15
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_run,
  input wire i_tick,
  input wire i_updown,
  input wire [W-1:0] i_top,
  input wire [4*W-1:0] i_cmp,
  input wire [3:0] i_pol,
  output reg o_period_end,
  output reg [3:0] o_out
);
  reg [W-1:0] cnt_ff;
  reg down_ff;
  wire at_end = i_updown ? (down_ff && cnt_ff <= {{(W-1){1'b0}}, 1'b1}) :
    (cnt_ff >= i_top - 1'b1);
  integer k;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= {W{1'b0}};
      down_ff <= 1'b0;
      o_period_end <= 1'b0;
      o_out <= 4'h0;
    end else begin
      o_period_end <= 1'b0;
      if (!i_run) begin
        cnt_ff <= {W{1'b0}};
        down_ff <= 1'b0;
      end else if (i_tick) begin
        if (at_end) begin
          cnt_ff <= {W{1'b0}};
          down_ff <= 1'b0;
          o_period_end <= 1'b1;
        end else if (i_updown && !down_ff && cnt_ff >= i_top - 1'b1) begin
          down_ff <= 1'b1;
          cnt_ff <= i_top;
        end else if (down_ff) begin
          cnt_ff <= cnt_ff - 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
      for (k = 0; k < 4; k = k + 1) begin
        o_out[k] <= i_run & ((cnt_ff < i_cmp[k*W +: W]) ^ i_pol[k]);
      end
    end
  end
endmodule // pwm_wave_counter

// file: rtl/pwm_sequence_decoder.v
// Sequence decoder of a four-channel PWM unit with APB registers and a DMA read master.
// Function
// - Each fetched half word: bit 15 polarity, bits 14:0 compare value.
// - Load field selects common, grouped or individual routing to compare channels.
// - Grouped consumes one half word per group; individual one per channel.
// - Arbitrary_wave_load load: channels 0-2, four words per step, fourth replaces period top.
// - Arbitrary_wave_load ignores top register; else new top applies at period end.
// - Extra-period count N applies a new value every N+1 periods.
// - Manual advance ignores extra periods and delay; each advance task loads next.
// - Begin task while idle fetches first value, then starts generation.
// - Begun event raised when first value fetched and executing.
// - Repeat zero plays once; finished event after last value; last value held.
// - Stop halts at period end, raises halted event, pins go idle.
// - After stop, only a begin task restarts from that sequence pointer.
// - Pointer and length captured when the begin task is issued and when repeated playback switches to the other sequence.
// - Extra count and delay sampled at begin and at each applied value.
// - Direction and decoder act immediately when written; divider at next tick, repeat count at begin.
// - At end of repeated playback extra count ignored; sequence 1 delay runs, then last held.
// - Nonzero repeat: seq0, delay0, seq1, delay1, again; start with chosen one.
// - Repeated playback always ends with the trailing delay of sequence 1.
// - Repeat count sets how many times sequence 1 chains after sequence 0.
// - All-repeats-done event raised after the repeat count of playbacks.
// - Advance task updates compare at next period and never starts generation.
// - If a fetch is late the previous compare value repeats.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "pwm_seq_defines.vh"
module pwm_sequence_decoder (
  input wire I_SYS_CLK,
  input wire I_RST,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [11:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output reg [31:0] O_PRDATA,
  output reg O_PREADY,
  output reg O_PSLVERR,
  output reg O_DMA_REQ,
  output reg [31:0] O_DMA_ADDR,
  input wire I_DMA_ACK,
  input wire [15:0] I_DMA_RDATA,
  output reg [3:0] O_PWM_OUT,
  output reg [3:0] O_PWM_OE
);
  localparam S_IDLE = 5'h01;
  localparam S_FETCH = 5'h02;
  localparam S_WAIT = 5'h04;
  localparam S_DELAY = 5'h08;
  localparam S_HOLD = 5'h10;
  reg [4:0] st_ff;
  reg enable_ff;
  reg updown_ff;
  reg [14:0] top_reg_ff;
  reg [14:0] top_ff;
  reg [3:0] div_ff;
  reg [1:0] load_ff;
  reg manual_ff;
  reg [15:0] repeat_ff;
  reg [31:0] ptr_reg_ff [0:1];
  reg [14:0] len_reg_ff [0:1];
  reg [23:0] extra_reg_ff [0:1];
  reg [23:0] delay_reg_ff [0:1];
  reg [6:0] evt_ff;
  reg [31:0] ptr_ff;
  reg [14:0] len_ff;
  reg [14:0] idx_ff;
  reg seq_ff;
  reg [23:0] extra_ff;
  reg [23:0] delay_ff;
  reg [23:0] wait_ff;
  reg [15:0] loops_ff;
  reg [1:0] word_ff;
  reg [15:0] buf_ff [0:3];
  reg [59:0] cmp_ff;
  reg [3:0] pol_ff;
  reg pend_ff;
  reg first_ff;
  reg run_ff;
  reg stop_ff;
  reg adv_ff;
  reg [3:0] pre_ff;
  wire per_end;
  wire [3:0] wave;
  wire tick = (pre_ff == 4'h0);
  wire acc = I_PSEL & I_PENABLE & O_PREADY;
  wire wr = acc & I_PWRITE;
  wire wr_task = wr & I_PWDATA[0];
  wire sel = ({I_PADDR[11:4], 4'h0} == `REG_SEQ1_BASE);
  wire in_seq = ({I_PADDR[11:4], 4'h0} == `REG_SEQ0_BASE) | sel;
  wire [11:0] seq_ofs = {8'h00, I_PADDR[3:0]};
  wire [2:0] words = (load_ff == `LOAD_COMMON) ? 3'h1 :
    (load_ff == `LOAD_GROUPED) ? 3'h2 : 3'h4;
  wire last_word = ({1'b0, word_ff} == words - 3'h1);
  wire seq_done = (idx_ff >= len_ff);
  wire [3:0] nxt_oe = {4{run_ff & enable_ff}} & ((load_ff == `LOAD_WAVE) ? 4'h7 : 4'hf);
  wire [63:0] routed;

  // Routing of the buffered half words onto the four compare channels.
  function [15:0] route;
    input [1:0] mode;
    input integer ch;
    input [63:0] b;
    begin
      case (mode)
        `LOAD_COMMON: route = b[15:0];
        `LOAD_GROUPED: route = ch[1] ? b[31:16] : b[15:0];
        default: route = b[ch*16 +: 16];
      endcase
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_route
      assign routed[g*16 +: 16] = route(load_ff, g,
        {buf_ff[3], buf_ff[2], buf_ff[1], buf_ff[0]});
    end
  endgenerate

  pwm_wave_counter #(.W(15)) u_wave (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_run(run_ff),
    .i_tick(tick),
    .i_updown(updown_ff),
    .i_top(top_ff),
    .i_cmp(cmp_ff),
    .i_pol(pol_ff),
    .o_period_end(per_end),
    .o_out(wave)
  );

  always @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      pre_ff <= 4'h0;
    end else if (!run_ff || tick) begin
      pre_ff <= div_ff;
    end else begin
      pre_ff <= pre_ff - 4'h1;
    end
  end

  // Register file; task writes act on the main state machine below.
  always @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      enable_ff <= 1'b0;
      updown_ff <= 1'b0;
      top_reg_ff <= `TOP_RESET;
      div_ff <= 4'h0;
      load_ff <= `LOAD_COMMON;
      manual_ff <= 1'b0;
      repeat_ff <= 16'h0000;
      ptr_reg_ff[0] <= 32'h00000000;
      ptr_reg_ff[1] <= 32'h00000000;
      len_reg_ff[0] <= 15'h0000;
      len_reg_ff[1] <= 15'h0000;
      extra_reg_ff[0] <= 24'h000000;
      extra_reg_ff[1] <= 24'h000000;
      delay_reg_ff[0] <= 24'h000000;
      delay_reg_ff[1] <= 24'h000000;
      O_PRDATA <= 32'h00000000;
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY <= I_PSEL & ~I_PENABLE;
      O_PSLVERR <= 1'b0;
      if (wr) begin
        case (I_PADDR)
          `REG_ENABLE: enable_ff <= I_PWDATA[0];
          `REG_COUNT_DIR: updown_ff <= I_PWDATA[0];
          `REG_PERIOD_TOP: top_reg_ff <= I_PWDATA[14:0];
          `REG_CLK_DIV: div_ff <= I_PWDATA[3:0];
          `REG_DECODER: begin
            load_ff <= I_PWDATA[`DEC_LOAD_LSB +: 2];
            manual_ff <= I_PWDATA[`DEC_MODE_BIT];
          end
          `REG_REPEAT: repeat_ff <= I_PWDATA[15:0];
          default: begin
            if (in_seq) begin
              case (seq_ofs)
                `SEQ_PTR_OFS: ptr_reg_ff[sel] <= I_PWDATA;
                `SEQ_LEN_OFS: len_reg_ff[sel] <= I_PWDATA[14:0];
                `SEQ_EXTRA_OFS: extra_reg_ff[sel] <= I_PWDATA[23:0];
                default: delay_reg_ff[sel] <= I_PWDATA[23:0];
              endcase
            end
          end
        endcase
      end
      if (I_PSEL & ~I_PENABLE & ~I_PWRITE) begin
        case (I_PADDR)
          `REG_EVT_HALTED: O_PRDATA <= {31'h0, evt_ff[0]};
          `REG_EVT_BEGUN0: O_PRDATA <= {31'h0, evt_ff[1]};
          `REG_EVT_BEGUN1: O_PRDATA <= {31'h0, evt_ff[2]};
          `REG_EVT_FINISHED0: O_PRDATA <= {31'h0, evt_ff[3]};
          `REG_EVT_FINISHED1: O_PRDATA <= {31'h0, evt_ff[4]};
          `REG_EVT_PERIOD: O_PRDATA <= {31'h0, evt_ff[5]};
          `REG_EVT_REPEATS: O_PRDATA <= {31'h0, evt_ff[6]};
          `REG_ENABLE: O_PRDATA <= {31'h0, enable_ff};
          `REG_COUNT_DIR: O_PRDATA <= {31'h0, updown_ff};
          `REG_PERIOD_TOP: O_PRDATA <= {17'h0, top_reg_ff};
          `REG_CLK_DIV: O_PRDATA <= {28'h0, div_ff};
          `REG_DECODER: O_PRDATA <= {23'h0, manual_ff, 6'h0, load_ff};
          `REG_REPEAT: O_PRDATA <= {16'h0, repeat_ff};
          `REG_STATUS: O_PRDATA <= {26'h0, seq_ff, run_ff, st_ff[3:0]};
          default: begin
            if (in_seq) begin
              case (seq_ofs)
                `SEQ_PTR_OFS: O_PRDATA <= ptr_reg_ff[sel];
                `SEQ_LEN_OFS: O_PRDATA <= {17'h0, len_reg_ff[sel]};
                `SEQ_EXTRA_OFS: O_PRDATA <= {8'h0, extra_reg_ff[sel]};
                default: O_PRDATA <= {8'h0, delay_reg_ff[sel]};
              endcase
            end else begin
              O_PRDATA <= 32'h00000000;
            end
          end
        endcase
      end
    end
  end

  // Sequencer: fetch, apply at period end, extra periods, trailing delays, repeats.
  integer c;
  always @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_ff <= S_IDLE;
      evt_ff <= 7'h00;
      ptr_ff <= 32'h00000000;
      len_ff <= 15'h0000;
      idx_ff <= 15'h0000;
      seq_ff <= 1'b0;
      extra_ff <= 24'h000000;
      delay_ff <= 24'h000000;
      wait_ff <= 24'h000000;
      loops_ff <= 16'h0000;
      word_ff <= 2'h0;
      buf_ff[0] <= 16'h0000;
      buf_ff[1] <= 16'h0000;
      buf_ff[2] <= 16'h0000;
      buf_ff[3] <= 16'h0000;
      cmp_ff <= 60'h0;
      pol_ff <= 4'h0;
      top_ff <= `TOP_RESET;
      pend_ff <= 1'b0;
      first_ff <= 1'b0;
      run_ff <= 1'b0;
      stop_ff <= 1'b0;
      adv_ff <= 1'b0;
      O_DMA_REQ <= 1'b0;
      O_DMA_ADDR <= 32'h00000000;
      O_PWM_OUT <= 4'h0;
      O_PWM_OE <= 4'h0;
    end else begin
      // Pins and enables come from the same cycle, so no pin is driven after its enable drops.
      O_PWM_OUT <= wave & nxt_oe;
      O_PWM_OE <= nxt_oe;
      if (wr && I_PADDR[11:8] == 4'h1 && !I_PWDATA[0]) begin
        case (I_PADDR)
          `REG_EVT_HALTED: evt_ff[0] <= 1'b0;
          `REG_EVT_BEGUN0: evt_ff[1] <= 1'b0;
          `REG_EVT_BEGUN1: evt_ff[2] <= 1'b0;
          `REG_EVT_FINISHED0: evt_ff[3] <= 1'b0;
          `REG_EVT_FINISHED1: evt_ff[4] <= 1'b0;
          `REG_EVT_PERIOD: evt_ff[5] <= 1'b0;
          `REG_EVT_REPEATS: evt_ff[6] <= 1'b0;
          default: begin
          end
        endcase
      end
      if (per_end) begin
        evt_ff[5] <= 1'b1;
        if (load_ff != `LOAD_WAVE) begin
          top_ff <= top_reg_ff;
        end
      end
      if (wr_task && I_PADDR == `REG_TASK_ADVANCE && manual_ff && run_ff) begin
        adv_ff <= 1'b1;
      end
      if (wr_task && I_PADDR == `REG_TASK_STOP && run_ff) begin
        stop_ff <= 1'b1;
      end
      if (stop_ff && per_end) begin
        stop_ff <= 1'b0;
        run_ff <= 1'b0;
        evt_ff[0] <= 1'b1;
        O_DMA_REQ <= 1'b0;
        pend_ff <= 1'b0;
        st_ff <= S_IDLE;
      end else if (enable_ff && wr_task &&
                   (I_PADDR == `REG_TASK_BEGIN0 || I_PADDR == `REG_TASK_BEGIN1)) begin
        seq_ff <= I_PADDR[2];
        ptr_ff <= ptr_reg_ff[I_PADDR[2]];
        len_ff <= len_reg_ff[I_PADDR[2]];
        extra_ff <= extra_reg_ff[I_PADDR[2]];
        delay_ff <= delay_reg_ff[I_PADDR[2]];
        loops_ff <= repeat_ff;
        idx_ff <= 15'h0000;
        word_ff <= 2'h0;
        first_ff <= 1'b1;
        pend_ff <= 1'b0;
        stop_ff <= 1'b0;
        O_DMA_REQ <= 1'b0;
        st_ff <= S_FETCH;
      end else begin
        case (st_ff)
          S_FETCH: begin
            if (!O_DMA_REQ) begin
              O_DMA_REQ <= 1'b1;
              O_DMA_ADDR <= ptr_ff + {16'h0, idx_ff, 1'b0};
            end else if (I_DMA_ACK) begin
              O_DMA_REQ <= 1'b0;
              buf_ff[word_ff] <= I_DMA_RDATA;
              idx_ff <= idx_ff + 15'h0001;
              word_ff <= word_ff + 2'h1;
              if (last_word) begin
                word_ff <= 2'h0;
                pend_ff <= 1'b1;
                wait_ff <= extra_ff;
                st_ff <= S_WAIT;
              end
            end
          end
          S_WAIT: begin
            // A value waits for a period end, except the first one while not running; a late fetch leaves the old one running.
            if (pend_ff && (first_ff && !run_ff || per_end &&
                (manual_ff ? adv_ff : wait_ff == 24'h0 || first_ff))) begin
              pend_ff <= 1'b0;
              adv_ff <= 1'b0;
              for (c = 0; c < 4; c = c + 1) begin
                cmp_ff[c*15 +: 15] <= routed[c*16 +: 15];
                pol_ff[c] <= routed[c*16 + `POL_BIT];
              end
              if (load_ff == `LOAD_WAVE) begin
                top_ff <= buf_ff[3][14:0];
              end else if (!run_ff) begin
                top_ff <= top_reg_ff;
              end
              run_ff <= 1'b1;
              extra_ff <= extra_reg_ff[seq_ff];
              delay_ff <= delay_reg_ff[seq_ff];
              if (first_ff) begin
                first_ff <= 1'b0;
                evt_ff[1 + seq_ff] <= 1'b1;
              end
              if (seq_done) begin
                evt_ff[3 + seq_ff] <= 1'b1;
                wait_ff <= delay_reg_ff[seq_ff];
                if (loops_ff == 16'h0 || manual_ff) begin
                  st_ff <= S_HOLD;
                end else begin
                  st_ff <= S_DELAY;
                end
              end else begin
                st_ff <= S_FETCH;
              end
            end else if (per_end && !manual_ff && wait_ff != 24'h0) begin
              wait_ff <= wait_ff - 24'h000001;
            end
          end
          S_DELAY: begin
            if (per_end) begin
              if (wait_ff != 24'h0) begin
                wait_ff <= wait_ff - 24'h000001;
              end else if (seq_ff) begin
                loops_ff <= loops_ff - 16'h0001;
                if (loops_ff == 16'h0001) begin
                  evt_ff[6] <= 1'b1;
                  st_ff <= S_HOLD;
                end else begin
                  seq_ff <= 1'b0;
                  ptr_ff <= ptr_reg_ff[0];
                  len_ff <= len_reg_ff[0];
                  idx_ff <= 15'h0000;
                  first_ff <= 1'b1;
                  st_ff <= S_FETCH;
                end
              end else begin
                seq_ff <= 1'b1;
                ptr_ff <= ptr_reg_ff[1];
                len_ff <= len_reg_ff[1];
                idx_ff <= 15'h0000;
                first_ff <= 1'b1;
                st_ff <= S_FETCH;
              end
            end
          end
          S_HOLD: begin
            st_ff <= S_HOLD;
          end
          S_IDLE: begin
            st_ff <= S_IDLE;
          end
          default: begin
            st_ff <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule // pwm_sequence_decoder

// file: sim/ram_model.sv
// Behavioural system RAM that answers the decoder's half-word read requests.
`timescale 1ns/1ps
module ram_model (
  input wire logic clk,
  input wire logic req,
  input wire logic [31:0] addr,
  input wire logic [1:0] lat,
  output logic ack,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:255];
  logic [1:0] wait_ff;
  initial begin
    ack = 1'b0;
    rdata = 16'h0000;
    wait_ff = 2'h0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h8000 | 16'(i);
    end
  end
  // Data is valid only with ack; otherwise the bus toggles so a stale capture shows up.
  always @(posedge clk) begin
    if (req && !ack && wait_ff == lat) begin
      ack <= 1'b1;
      rdata <= mem[addr[8:1]];
      wait_ff <= 2'h0;
    end else begin
      ack <= 1'b0;
      rdata <= ~rdata;
      if (req && !ack) begin
        wait_ff <= wait_ff + 2'h1;
      end
    end
  end
endmodule // ram_model

// file: sim/pwm_seq_chk.sv
// Concurrent checks on the decoder's bus, DMA and wave ports.
`timescale 1ns/1ps
module pwm_seq_chk (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic O_DMA_REQ,
  input wire logic [31:0] O_DMA_ADDR,
  input wire logic I_DMA_ACK,
  input wire logic [3:0] O_PWM_OUT,
  input wire logic [3:0] O_PWM_OE
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  bus_ready_a: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
    else $error("pready longer than one cycle");
  ready_phase_a: assert property (O_PREADY |-> I_PSEL && I_PENABLE)
    else $error("pready outside access phase");
  no_slverr_a: assert property (!O_PSLVERR)
    else $error("pslverr raised");
  dma_hold_a: assert property (O_DMA_REQ && !I_DMA_ACK |=> O_DMA_REQ && $stable(O_DMA_ADDR))
    else $error("dma request not held");
  dma_drop_a: assert property (O_DMA_REQ && I_DMA_ACK |=> !O_DMA_REQ)
    else $error("dma request not dropped");
  dma_align_a: assert property (O_DMA_REQ |-> !O_DMA_ADDR[0])
    else $error("dma address not half-word aligned");
  idle_pins_a: assert property (O_PWM_OUT != 4'h0 |-> O_PWM_OE != 4'h0)
    else $error("wave output active while idle");
endmodule // pwm_seq_chk

// file: sim/tb_top.sv
// Self-checking bench for the sequence decoder.
`timescale 1ns/1ps
`include "pwm_seq_defines.vh"
module tb_top;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, dma_req, dma_ack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, dma_addr, first_addr;
  logic [15:0] dma_rdata;
  logic [3:0] pwm_out, pwm_oe;
  logic [1:0] lat;
  int n_errors, comparisons, n_fetch;
  pwm_sequence_decoder dut_u (.I_SYS_CLK(clk), .I_RST(rst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_DMA_REQ(dma_req),
    .O_DMA_ADDR(dma_addr), .I_DMA_ACK(dma_ack), .I_DMA_RDATA(dma_rdata),
    .O_PWM_OUT(pwm_out), .O_PWM_OE(pwm_oe));
  ram_model ram_u (.clk(clk), .req(dma_req), .addr(dma_addr), .lat(lat), .ack(dma_ack),
    .rdata(dma_rdata));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (dma_req && dma_ack) begin
      if (n_fetch == 0) first_addr <= dma_addr;
      n_fetch <= n_fetch + 1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // Polls an event flag under a bound, then clears it.
  task automatic wait_evt(input logic [11:0] a);
    logic [31:0] q;
    int n;
    q = 32'h0;
    n = 0;
    while (q[0] !== 1'b1 && n < 400) begin
      apb(1'b0, a, 32'h0, q);
      n++;
    end
    chk(q, 32'h1);
    wr(a, 32'h0);
  endtask
  task automatic seq_cfg(input bit s, input logic [31:0] ptr, input logic [31:0] len,
    input logic [31:0] dly);
    logic [11:0] b;
    b = s ? `REG_SEQ1_BASE : `REG_SEQ0_BASE;
    wr(b + `SEQ_PTR_OFS, ptr);
    wr(b + `SEQ_LEN_OFS, len);
    wr(b + `SEQ_EXTRA_OFS, 32'h0);
    wr(b + `SEQ_DELAY_OFS, dly);
  endtask
  task automatic s_stop;
    wr(`REG_TASK_STOP, 32'h1);
    wait_evt(`REG_EVT_HALTED);
    chk({28'h0, pwm_oe}, 32'h0);
    chk({28'h0, pwm_out}, 32'h0);
    n_fetch = 0;
  endtask
  task automatic s_regs;
    rdc(`REG_PERIOD_TOP, {17'h0, `TOP_RESET});
    wr(12'h7fc, 32'h5);
    rdc(12'h7fc, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
  endtask
  task automatic s_load(input logic [1:0] m, input logic [31:0] len, input logic [3:0] oe);
    logic [31:0] hi;
    wr(`REG_DECODER, {30'h0, m});
    seq_cfg(1'b0, 32'h40, len, 32'h0);
    wr(`REG_TASK_BEGIN0, 32'h1);
    wait_evt(`REG_EVT_BEGUN0);
    chk({28'h0, pwm_oe}, {28'h0, oe});
    wait_evt(`REG_EVT_FINISHED0);
    repeat (40) @(posedge clk);
    chk(n_fetch, len);
    chk(first_addr, 32'h40);
    chk({28'h0, pwm_oe}, {28'h0, oe});
    // High cycles per channel, one byte each, over 78 cycles: two periods of the held Arbitrary_wave_load last step.
    // Arbitrary_wave_load step: top 39, compares 36 to 38 inverted by bit 15; other modes exceed top 8.
    hi = 32'h0;
    repeat (78) begin
      @(posedge clk);
      hi = hi + {7'h0, pwm_out[3], 7'h0, pwm_out[2], 7'h0, pwm_out[1], 7'h0, pwm_out[0]};
    end
    chk(hi, (m == `LOAD_WAVE) ? 32'h00020406 : 32'h0);
    s_stop();
  endtask
  task automatic s_loop;
    lat = 2'h3;
    wr(`REG_COUNT_DIR, 32'h1);
    wr(`REG_DECODER, 32'h0);
    wr(`REG_REPEAT, 32'h1);
    seq_cfg(1'b0, 32'h40, 32'h2, 32'h1);
    seq_cfg(1'b1, 32'h80, 32'h2, 32'h1);
    wr(`REG_TASK_BEGIN0, 32'h1);
    wait_evt(`REG_EVT_REPEATS);
    chk(n_fetch, 32'h4);
    chk(first_addr, 32'h40);
    wait_evt(`REG_EVT_BEGUN0);
    wait_evt(`REG_EVT_BEGUN1);
    s_stop();
    wr(`REG_REPEAT, 32'h0);
    wr(`REG_COUNT_DIR, 32'h0);
    lat = 2'h0;
  endtask
  task automatic s_manual;
    int k;
    wr(`REG_DECODER, 32'h100);
    seq_cfg(1'b0, 32'h40, 32'h3, 32'h1);
    wr(`REG_TASK_BEGIN0, 32'h1);
    wait_evt(`REG_EVT_BEGUN0);
    repeat (50) @(posedge clk);
    k = n_fetch;
    repeat (100) @(posedge clk);
    chk(n_fetch, k);
    wr(`REG_TASK_ADVANCE, 32'h1);
    repeat (50) @(posedge clk);
    chk(n_fetch, k + 1);
    s_stop();
    wr(`REG_TASK_ADVANCE, 32'h1);
    repeat (50) @(posedge clk);
    chk({28'h0, pwm_oe}, 32'h0);
    chk(n_fetch, 32'h0);
  endtask
  task automatic print_verdict;
    $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lat = 2'h0;
    n_fetch = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_regs();
    wr(`REG_ENABLE, 32'h1);
    wr(`REG_PERIOD_TOP, 32'h8);
    wr(`REG_CLK_DIV, 32'h0);
    wr(`REG_REPEAT, 32'h0);
    s_load(`LOAD_COMMON, 32'h3, 4'hf);
    s_load(`LOAD_GROUPED, 32'h4, 4'hf);
    s_load(`LOAD_INDIVIDUAL, 32'h8, 4'hf);
    s_load(`LOAD_WAVE, 32'h8, 4'h7);
    s_loop();
    s_manual();
    print_verdict();
  end
endmodule // tb_top
bind pwm_sequence_decoder pwm_seq_chk chk_u (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .O_DMA_REQ(O_DMA_REQ), .O_DMA_ADDR(O_DMA_ADDR), .I_DMA_ACK(I_DMA_ACK),
  .O_PWM_OUT(O_PWM_OUT), .O_PWM_OE(O_PWM_OE));
